// ---- bus_overvoltage_pwm_break_tb_top.sv ----
`include "ovg_consts.svh"
module bus_overvoltage_pwm_break_tb_top
	import ovg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, ocFault = 0, safe_q;
	logic [47:0] senseIn = '0;
	logic [11:0] extRef = '0, dacCode_q;
	logic firstBreak_q, secondBreakInput_q, pwmDisable_q, lowSideOn_q;
	logic dacOut_q, cmpPin_q, cmpPinOe_n_q, irq_q;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata_q;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [15:0] rnd = 16'h002D;
	int n_fail = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	overvoltage_guard i_overvoltage_guard (.clk, .rst, .senseIn, .extRef,
		.ocFault, .firstBreak_q, .secondBreakInput_q, .pwmDisable_q,
		.lowSideOn_q, .dacOut_q, .dacCode_q, .cmpPin_q, .cmpPinOe_n_q,
		.irq_q, .awaddr, .awvalid, .awready_q, .wdata, .wstrb, .wvalid,
		.wready_q, .bresp_q, .bvalid_q, .bready, .araddr, .arvalid,
		.arready_q, .rdata_q, .rresp_q, .rvalid_q, .rready);
	power_stage_model i_power_stage_model (.clk, .breakReq(secondBreakInput_q),
		.pwmOff(pwmDisable_q), .lowOn(lowSideOn_q), .safe_q);
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic hang(input int n);
		if (n >= 40) begin
			n_fail++;
			close_out();
		end
	endtask : hang
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= {24'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (awready_q !== 1'b1 && n < 40);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid_q !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		bready <= 1'b0;
		hang(n);
		chk(bresp_q, er);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= {24'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (arready_q !== 1'b1 && n < 40);
		arvalid <= 1'b0;
		while (rvalid_q !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		rready <= 1'b0;
		hang(n);
		chk(rdata_q, ed);
		chk(rresp_q, er);
	endtask : rd
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : nxt
	function automatic logic [47:0] lanes(input logic [1:0] p,
			input logic [11:0] v, input logic [11:0] o);
		lanes = {4{o}};
		lanes[12*p +: 12] = v;
	endfunction : lanes
	function automatic logic [11:0] thr(input int r, input int l,
			input logic [11:0] v);
		logic [11:0] lv[4] = '{`INTLVL0, `INTLVL1, `INTLVL2, `INTLVL3};
		return (r == 1 || r == 2) ? v : lv[l];
	endfunction : thr
	initial begin
		int r, l;
		logic [1:0] p;
		logic a, oe;
		logic [11:0] v, t;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		senseIn <= '1;
		ocFault <= 1'b1;
		tick(4);
		chk(secondBreakInput_q, 0);
		chk(firstBreak_q, 1);
		@(posedge clk);
		ocFault <= 1'b0;
		rd(`OFF_CTRL, 0, `RESP_OK);
		rd(`OFF_DACREF, 32'h0FFF, `RESP_OK);
		rd(`OFF_IRQMASK, 0, `RESP_OK);
		rd(`OFF_FAULTCLR, 0, `RESP_OK);
		rd(8'h18, 0, `RESP_SLVERR);
		wr(8'h40, 1, `RESP_SLVERR);
		for (int i = 0; i < 6; i++) begin
			repeat (16) rnd = nxt(rnd);
			r = i % 4;
			l = i % 3;
			{oe, a, p} = rnd[3:0];
			v = rnd[15:4] & 12'hFFE;
			t = thr(r, l, v);
			@(posedge clk);
			extRef <= v;
			// Park every lane low so a config change cannot trip early
			senseIn <= '0;
			if (r == 2) wr(`OFF_DACREF, {20'h0, v}, `RESP_OK);
			wr(`OFF_CTRL, {23'h0, oe, a, p, l[1:0], r[1:0], 1'b1}, `RESP_OK);
			tick(2);
			chk(dacOut_q, r == 2);
			if (r == 2) chk(dacCode_q, v);
			chk(cmpPinOe_n_q, !oe);
			@(posedge clk);
			senseIn <= lanes(p, t, t + 12'h001);
			tick(4);
			chk(secondBreakInput_q, 0);
			@(posedge clk);
			senseIn <= lanes(p, t + 12'h001, 12'h000);
			tick(2);
			chk(secondBreakInput_q, 0);
			tick(1);
			chk(secondBreakInput_q, 1);
			chk(pwmDisable_q, !a);
			chk(lowSideOn_q, a);
			chk(firstBreak_q, 0);
			chk(cmpPin_q, oe);
			tick(1);
			chk(safe_q, 1);
			chk(irq_q, i != 0);
			rd(`OFF_STATUS, 32'h0000_000E, `RESP_OK);
			wr(`OFF_FAULTCLR, 1, `RESP_OK);
			tick(3);
			chk(secondBreakInput_q, 1);
			@(posedge clk);
			senseIn <= lanes(p, 12'h000, 12'hFFF);
			tick(4);
			chk(secondBreakInput_q, 1);
			wr(`OFF_FAULTCLR, 1, `RESP_OK);
			tick(3);
			chk(secondBreakInput_q, 0);
			chk(pwmDisable_q | lowSideOn_q, 0);
			rd(`OFF_IRQSTAT, 3, `RESP_OK);
			wr(`OFF_IRQSTAT, 3, `RESP_OK);
			rd(`OFF_IRQSTAT, 0, `RESP_OK);
			tick(2);
			chk(irq_q, 0);
			if (i == 0) wr(`OFF_IRQMASK, 3, `RESP_OK);
		end
		// Top internal level: no 12-bit sample can exceed it
		wr(`OFF_CTRL, 32'h0000_0019, `RESP_OK);
		rd(`OFF_CTRL, 32'h0000_0019, `RESP_OK);
		@(posedge clk);
		senseIn <= '1;
		tick(4);
		chk(secondBreakInput_q, 0);
		close_out();
	end
endmodule : bus_overvoltage_pwm_break_tb_top

// ---- overvoltage_guard.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`include "ovg_consts.svh"

module overvoltage_guard
	import ovg_pkg::*;
(
	input wire logic clk, // 200 MHz clock
	input wire logic rst, // Sync reset, active high
	input wire logic [47:0] senseIn, // Four 12-bit bus voltage samples
	input wire logic [11:0] extRef, // External reference pin level
	input wire logic ocFault, // Overcurrent comparator level
	output logic firstBreak_q, // Overcurrent break request
	output logic secondBreakInput_q, // Overvoltage break request
	output logic pwmDisable_q, // Disable all PWM outputs
	output logic lowSideOn_q, // Force low-side switches on
	output logic dacOut_q, // DAC channel dedicated to threshold
	output logic [11:0] dacCode_q, // DAC channel code
	output logic cmpPin_q, // Comparator output pin value
	output logic cmpPinOe_n_q, // Pin output enable, low drives
	output logic irq_q, // Interrupt, level
	input wire logic [31:0] awaddr, // AXI4-Lite
	input wire logic awvalid, // AXI4-Lite
	output logic awready_q, // AXI4-Lite
	input wire logic [31:0] wdata, // AXI4-Lite
	input wire logic [3:0] wstrb, // AXI4-Lite
	input wire logic wvalid, // AXI4-Lite
	output logic wready_q, // AXI4-Lite
	output logic [1:0] bresp_q, // AXI4-Lite
	output logic bvalid_q, // AXI4-Lite
	input wire logic bready, // AXI4-Lite
	input wire logic [31:0] araddr, // AXI4-Lite
	input wire logic arvalid, // AXI4-Lite
	output logic arready_q, // AXI4-Lite
	output logic [31:0] rdata_q, // AXI4-Lite
	output logic [1:0] rresp_q, // AXI4-Lite
	output logic rvalid_q, // AXI4-Lite
	input wire logic rready // AXI4-Lite
);
	logic [`CTRL_W-1:0] ctrl_q;
	logic [11:0] dacRef_q;
	logic [1:0] irqStat_q;
	logic [1:0] irqMask_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic above_q;
	logic fault_q;
	logic faultClr;
	logic wrEn;
	logic wrOk;
	sample_t sample;
	sample_t threshold;
	sample_t intLevel;
	refsel_t refSel;
	action_t action;
	logic [1:0] pinSel;
	logic aboveNow;
	logic tripEv;
	logic safeEv;

	assign refSel = refsel_t'(ctrl_q[`CTRL_REF_LO +: 2]);
	assign action = action_t'(ctrl_q[`CTRL_ACT]);
	assign pinSel = ctrl_q[`CTRL_PIN_LO +: 2];

	// Sense pin choice selects which 12-bit sample the single comparator sees
	assign sample = senseIn[pinSel*12 +: 12];

	always_comb begin
		case (ctrl_q[`CTRL_LVL_LO +: 2])
			2'd0: intLevel = `INTLVL0;
			2'd1: intLevel = `INTLVL1;
			2'd2: intLevel = `INTLVL2;
			default: intLevel = `INTLVL3;
		endcase
	end

	always_comb begin
		case (refSel)
			REF_INTERNAL: threshold = intLevel;
			REF_EXTERNAL: threshold = extRef;
			REF_DAC: threshold = dacRef_q;
			default: threshold = intLevel;
		endcase
	end

	assign aboveNow = ctrl_q[`CTRL_EN] && (sample > threshold);

	always_ff @(posedge clk) begin
		if (rst) begin
			above_q <= 1'b0;
		end else begin
			above_q <= aboveNow;
		end
	end

	// Latched fault; a new trip wins over a clear
	assign tripEv = above_q && !fault_q;
	assign safeEv = fault_q && !above_q && faultClr;
	always_ff @(posedge clk) begin
		if (rst) begin
			fault_q <= 1'b0;
		end else if (above_q) begin
			fault_q <= 1'b1;
		end else if (faultClr) begin
			fault_q <= 1'b0;
		end
	end

	// Break outputs: each fault on its own input
	always_ff @(posedge clk) begin
		if (rst) begin
			secondBreakInput_q <= 1'b0;
			firstBreak_q <= 1'b0;
			pwmDisable_q <= 1'b0;
			lowSideOn_q <= 1'b0;
		end else begin
			secondBreakInput_q <= fault_q;
			firstBreak_q <= ocFault;
			pwmDisable_q <= fault_q && action == ACT_DISABLE_PWM;
			lowSideOn_q <= fault_q && action == ACT_LOWSIDE_ON;
		end
	end

	// Comparator pin is observation only
	always_ff @(posedge clk) begin
		if (rst) begin
			cmpPin_q <= 1'b0;
			cmpPinOe_n_q <= 1'b1;
			dacOut_q <= 1'b0;
			dacCode_q <= `DACREF_RST;
		end else begin
			cmpPin_q <= above_q && ctrl_q[`CTRL_OUTEN];
			cmpPinOe_n_q <= !ctrl_q[`CTRL_OUTEN];
			dacOut_q <= refSel == REF_DAC;
			dacCode_q <= dacRef_q;
		end
	end

	// AXI write: take address and data together, only once both are valid
	assign wrEn = bvalid_q == 1'b0 && awready_q == 1'b0 && wready_q == 1'b0
		&& awvalid && wvalid;
	always_ff @(posedge clk) begin
		if (rst) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `RESP_OK;
			awAddr_q <= 8'h00;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
		end else begin
			awready_q <= wrEn;
			wready_q <= wrEn;
			if (awready_q) begin
				awAddr_q <= awaddr[7:0];
				wData_q <= wdata;
				wStrb_q <= wstrb;
				bvalid_q <= 1'b1;
				bresp_q <= (awaddr[31:8] == 24'h0 && awaddr[1:0] == 2'b00
					&& awaddr[7:0] <= `OFF_FAULTCLR) ? `RESP_OK : `RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Register write applied in the cycle after acceptance
	logic wrPend_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPend_q <= 1'b0;
		end else begin
			wrPend_q <= awready_q;
		end
	end
	assign wrOk = wrPend_q && bresp_q == `RESP_OK;
	assign faultClr = wrOk && awAddr_q == `OFF_FAULTCLR && wStrb_q[0]
		&& wData_q[0];

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `CTRL_RST;
		end else if (wrOk && awAddr_q == `OFF_CTRL) begin
			if (wStrb_q[0]) begin
				ctrl_q[7:0] <= wData_q[7:0];
			end
			if (wStrb_q[1]) begin
				ctrl_q[8] <= wData_q[8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			dacRef_q <= `DACREF_RST;
		end else if (wrOk && awAddr_q == `OFF_DACREF) begin
			if (wStrb_q[0]) begin
				dacRef_q[7:0] <= wData_q[7:0];
			end
			if (wStrb_q[1]) begin
				dacRef_q[11:8] <= wData_q[11:8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqMask_q <= `MASK_RST;
		end else if (wrOk && awAddr_q == `OFF_IRQMASK && wStrb_q[0]) begin
			irqMask_q <= wData_q[1:0];
		end
	end

	// Sticky events, write one to clear, set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStat_q <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == `EV_TRIP && tripEv) || (i == `EV_SAFE && safeEv)) begin
					irqStat_q[i] <= 1'b1;
				end else if (wrOk && awAddr_q == `OFF_IRQSTAT && wStrb_q[0]
					&& wData_q[i]) begin
					irqStat_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irqStat_q & irqMask_q);
		end
	end

	// AXI read
	logic [31:0] rdMux;
	logic rdHit;
	always_comb begin
		rdMux = 32'h0000_0000;
		rdHit = araddr[31:8] == 24'h0 && araddr[1:0] == 2'b00;
		case (araddr[7:0])
			`OFF_CTRL: rdMux = {23'h0, ctrl_q};
			`OFF_DACREF: rdMux = {20'h0, dacRef_q};
			`OFF_STATUS: rdMux = {28'h0, secondBreakInput_q, fault_q,
				above_q, firstBreak_q};
			`OFF_IRQSTAT: rdMux = {30'h0, irqStat_q};
			`OFF_IRQMASK: rdMux = {30'h0, irqMask_q};
			`OFF_FAULTCLR: rdMux = 32'h0000_0000;
			default: rdHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `RESP_OK;
		end else begin
			arready_q <= arvalid && !arready_q && !rvalid_q;
			if (arready_q) begin
				rvalid_q <= 1'b1;
				rdata_q <= rdHit ? rdMux : 32'h0000_0000;
				rresp_q <= rdHit ? `RESP_OK : `RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	trip_latches_a: assert property (above_q |=> fault_q)
		else $error("Over-threshold sample did not latch fault");
	compare_seen_a: assert property (aboveNow |=> above_q)
		else $error("Comparison result lost");
	break_follows_a: assert property (
		above_q |=> ##1 secondBreakInput_q)
		else $error("Break not raised after fault");
	break_split_a: assert property (
		!fault_q && ocFault |=> !secondBreakInput_q)
		else $error("Overcurrent leaked onto second break");
	action_one_a: assert property (
		secondBreakInput_q |-> pwmDisable_q ^ lowSideOn_q)
		else $error("Safe action not applied exactly once");
	int_ref_a: assert property (
		refSel == REF_INTERNAL && ctrl_q[0]
		&& sample > intLevel |=> above_q)
		else $error("Internal reference not used");
	ext_ref_a: assert property (
		refSel == REF_EXTERNAL && ctrl_q[0]
		&& sample <= extRef |=> !above_q)
		else $error("External reference not used");
	dac_ref_a: assert property (
		refSel == REF_DAC && ctrl_q[0]
		&& sample > dacRef_q |=> above_q)
		else $error("DAC reference not used");
	pin_pick_a: assert property (
		threshold == 12'h000 && ctrl_q[0]
		&& senseIn[pinSel*12 +: 12] != 12'h000 |=> above_q)
		else $error("Selected sense pin ignored");
	pin_free_a: assert property (
		fault_q && !ctrl_q[`CTRL_OUTEN] |=> secondBreakInput_q)
		else $error("Break depends on output pin");
	latch_hold_a: assert property (
		fault_q && !faultClr |=> fault_q)
		else $error("Fault released without clear");
endmodule : overvoltage_guard

// ---- ovg_consts.svh ----
`ifndef OVG_CONSTS_SVH
`define OVG_CONSTS_SVH

// Register byte offsets
`define OFF_CTRL 8'h00
`define OFF_DACREF 8'h04
`define OFF_STATUS 8'h08
`define OFF_IRQSTAT 8'h0C
`define OFF_IRQMASK 8'h10
`define OFF_FAULTCLR 8'h14

// Control field positions
`define CTRL_EN 0
`define CTRL_REF_LO 1
`define CTRL_LVL_LO 3
`define CTRL_PIN_LO 5
`define CTRL_ACT 7
`define CTRL_OUTEN 8
`define CTRL_W 9

// Reset values
`define CTRL_RST 9'h000
`define DACREF_RST 12'hFFF
`define MASK_RST 2'h0

// Fixed internal reference levels (12-bit codes)
`define INTLVL0 12'h400
`define INTLVL1 12'h800
`define INTLVL2 12'hC00
`define INTLVL3 12'hFFF

// Interrupt event bits
`define EV_TRIP 0
`define EV_SAFE 1

`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- ovg_pkg.sv ----
package ovg_pkg;
	typedef enum logic [1:0] {
		REF_INTERNAL,
		REF_EXTERNAL,
		REF_DAC,
		REF_SPARE
	} refsel_t;

	typedef enum logic {
		ACT_DISABLE_PWM,
		ACT_LOWSIDE_ON
	} action_t;

	typedef logic [11:0] sample_t;
endpackage : ovg_pkg

// ---- power_stage_model.sv ----
module power_stage_model (
	input wire logic clk, // Timer clock
	input wire logic breakReq, // Break request
	input wire logic pwmOff, // PWM outputs forced off
	input wire logic lowOn, // Low sides forced on
	output logic safe_q // Stage in a safe state
);
	timeunit 1ns;
	timeprecision 1ps;
	// A break without exactly one action leaves the bridge unsafe
	always_ff @(posedge clk) begin
		safe_q <= breakReq & (pwmOff ^ lowOn);
	end
endmodule : power_stage_model
